// File: core/baud_pkg.sv
package baud_pkg;
   localparam logic [1:0] ADDR_RATE_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_FINE_PRESCALER = 2'h1;
   localparam logic [1:0] ADDR_BREAK_LENGTH = 2'h2;
   localparam logic [1:0] ADDR_STATUS = 2'h3;
   localparam logic [7:0] RATE_CONTROL_RESET = 8'h00;
   localparam logic [7:0] FINE_PRESCALER_RESET = 8'h00;
   localparam logic [7:0] RATE_CONTROL_MASK = 8'hf7;
   localparam int BRK_GEN_BIT = 7;
   localparam int BRK_DET_BIT = 6;
   localparam int COARSE_LSB = 4;
   localparam int COARSE_W = 2;
   localparam int POWER2_LSB = 0;
   localparam int POWER2_W = 3;
   localparam int PRESCALE_LSB = 5;
   localparam int PRESCALE_W = 3;
   localparam int INSERT_LSB = 0;
   localparam int INSERT_W = 5;
   localparam int FRAME_W = 5;
   localparam int STAT_ACTIVE_BIT = 0;
   localparam int STAT_RX_BIT = 1;
   localparam int STAT_SEEN_BIT = 2;
   localparam int STAT_PENDING_BIT = 3;
   localparam logic [3:0] COARSE_DIV_1 = 4'h1;
   localparam logic [3:0] COARSE_DIV_3 = 4'h3;
   localparam logic [3:0] COARSE_DIV_4 = 4'h4;
   localparam logic [3:0] COARSE_DIV_13 = 4'hd;
   localparam logic [2:0] PRESCALE_BYPASS = 3'h0;
   localparam logic [1:0] BUS_PHASE_LAST = 2'h3;
   localparam logic [1:0] RT_PRE_LAST = 2'h3;
   localparam logic [3:0] RT_PER_BIT_LAST = 4'hf;
   localparam logic [3:0] RT_SHIFT_ZERO = 4'h0;
   localparam logic [4:0] NORMAL_BITS_8 = 5'h0a;
   localparam logic [4:0] NORMAL_BITS_9 = 5'h0b;
   localparam logic [4:0] DETECT_BITS_8 = 5'h0b;
   localparam logic [4:0] DETECT_BITS_9 = 5'h0c;
   localparam logic [4:0] GEN_BITS_8 = 5'h0d;
   localparam logic [4:0] GEN_BITS_9 = 5'h0e;
   localparam logic [8:0] LIN_MIN_RT = 9'h0b0;
   localparam logic [8:0] LOW_RT_MAX = 9'h1ff;
   localparam logic [2:0] RX_SYNC_IDLE = 3'h7;
endpackage

// File: core/tick_divider.sv
`timescale 1ns/10ps
module tick_divider
   import baud_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic clear,
   input wire logic in_tick,
   input wire logic [W-1:0] divisor,
   output logic out_tick
);
   typedef struct packed {
      logic [W-1:0] count;
      logic out;
   } div_state_t;
   div_state_t st, next_st;

   always_comb begin
      next_st = st;
      next_st.out = 1'b0;
      if (clear) begin
         next_st.count = '0;
      end else if (in_tick) begin
         if (st.count >= W'(divisor - 1'b1)) begin
            next_st.count = '0;
            next_st.out = 1'b1;
         end else begin
            next_st.count = W'(st.count + 1'b1);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign out_tick = st.out;

   default clocking dc @(posedge ref_clk iff clk_en); endclocking
   default disable iff (rst);
   out_follows_a: assert property (out_tick |-> $past(in_tick) && !$past(clear))
      else $error("divider tick without an input tick");
endmodule

// File: core/frac_prescaler.sv
`timescale 1ns/10ps
module frac_prescaler
   import baud_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic clear,
   input wire logic in_tick,
   input wire logic [PRESCALE_W-1:0] prescale_select,
   input wire logic [INSERT_W-1:0] clock_insert_select,
   output logic out_tick
);
   typedef struct packed {
      logic [3:0] count;
      logic [FRAME_W-1:0] frame;
      logic out;
   } frac_state_t;
   frac_state_t st, next_st;
   logic [FRAME_W-1:0] frame_rev;
   logic bypass;
   logic stretch;
   logic [3:0] cycle_last;
   logic [3:0] seen;
   logic [3:0] pd;

   // Bit reversal spreads the stretched cycles evenly over the frame.
   for (genvar i = 0; i < FRAME_W; i++) begin : g_rev
      assign frame_rev[i] = st.frame[FRAME_W-1-i];
   end

   always_comb begin
      // Changing the select while serial_enable is high is not supported.
      bypass = (prescale_select == PRESCALE_BYPASS);
      stretch = (frame_rev < clock_insert_select);
      cycle_last = {1'b0, prescale_select} + {3'h0, stretch};
      next_st = st;
      next_st.out = 1'b0;
      if (clear) begin
         next_st.count = '0;
         next_st.frame = '0;
      end else if (in_tick) begin
         if (bypass || st.count >= cycle_last) begin
            next_st.count = '0;
            next_st.out = 1'b1;
            if (!bypass) begin
               next_st.frame = FRAME_W'(st.frame + 1'b1);
            end
         end else begin
            next_st.count = 4'(st.count + 1'b1);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign out_tick = st.out;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         seen <= 4'h0;
      end else if (clk_en) begin
         seen <= clear ? 4'h0 : 4'((out_tick ? 4'h0 : seen) + {3'h0, in_tick});
      end
   end
   assign pd = {1'b0, prescale_select} + 4'h1;

   default clocking dc @(posedge ref_clk iff clk_en); endclocking
   default disable iff (rst);
   bypass_pass_a: assert property (in_tick && bypass && !clear |=> out_tick)
      else $error("bypass did not pass an input tick");
   // A tick launched just before a settings write was counted with the old select.
   cycle_span_a: assert property (out_tick && !bypass && !clear
         |-> seen == pd || seen == 4'(pd + 1'b1))
      else $error("prescaler cycle length out of range");
endmodule

// File: core/serial_baud_rate_generator.sv
`timescale 1ns/10ps
// Notes on behaviour
// - One bit rate from both rate registers.
// - Receive break after 11 or 12 bits.
// - Transmit breaks of 13 or 14 bits.
// - Both enables: detect and generate together.
// - Zero character never mistaken for break.
// - Coarse select gives 1, 3, 4, 13.
// - Rate select divides by two to the power.
// - Reset clears the rate select field.
// - Prescale select zero bypasses, else select plus one.
// - Extra clocks inserted per 32-cycle frame.
// - Fine adjust equals insert count over 32.
// - Bit rate is source over 64 times divisors.
// - Source is bus or quad bus clock.
module serial_baud_rate_generator
   import baud_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   input wire logic serial_enable,
   input wire logic baud_clock_source_sel,
   input wire logic nine_bit_mode,
   input wire logic rx_pin,
   input wire logic send_break,
   output logic rt_tick,
   output logic bit_tick,
   output logic break_detected,
   output logic break_active
);
   typedef struct packed {
      logic [7:0] rate_control_reg;
      logic [7:0] fine_prescaler_reg;
      logic [7:0] rdata;
      logic [1:0] bus_phase;
      logic src_tick;
      logic clear;
      logic [1:0] rt_pre;
      logic rt_tick;
      logic [3:0] rt_count;
      logic bit_tick;
      logic [2:0] rx_sync;
      logic rx_level;
      logic [8:0] low_rt;
      logic armed;
      logic [4:0] break_len;
      logic break_seen;
      logic break_detected;
      logic gen_pending;
      logic break_active;
      logic [4:0] gen_count;
   } core_state_t;
   core_state_t st, next_st;

   logic break_generate_enable;
   logic break_detect_enable;
   logic [COARSE_W-1:0] coarse_prescale_sel;
   logic [POWER2_W-1:0] power2_rate_sel;
   logic [PRESCALE_W-1:0] prescale_select;
   logic [INSERT_W-1:0] clock_insert_select;
   logic [3:0] coarse_divisor;
   logic [7:0] power2_divisor;
   logic frac_tick;
   logic coarse_tick;
   logic power2_tick;
   logic [4:0] detect_bits;
   logic [4:0] gen_bits;
   logic [8:0] detect_rt;
   logic [7:0] status;
   logic rate_write;

   assign break_generate_enable = st.rate_control_reg[BRK_GEN_BIT];
   assign break_detect_enable = st.rate_control_reg[BRK_DET_BIT];
   assign coarse_prescale_sel = st.rate_control_reg[COARSE_LSB +: COARSE_W];
   assign power2_rate_sel = st.rate_control_reg[POWER2_LSB +: POWER2_W];
   assign prescale_select = st.fine_prescaler_reg[PRESCALE_LSB +: PRESCALE_W];
   assign clock_insert_select = st.fine_prescaler_reg[INSERT_LSB +: INSERT_W];

   always_comb begin
      unique case (coarse_prescale_sel)
         2'h0: coarse_divisor = COARSE_DIV_1;
         2'h1: coarse_divisor = COARSE_DIV_3;
         2'h2: coarse_divisor = COARSE_DIV_4;
         2'h3: coarse_divisor = COARSE_DIV_13;
      endcase
   end

   assign power2_divisor = 8'(8'h01 << power2_rate_sel);

   always_comb begin
      if (break_detect_enable) begin
         detect_bits = nine_bit_mode ? DETECT_BITS_9 : DETECT_BITS_8;
      end else begin
         detect_bits = nine_bit_mode ? NORMAL_BITS_9 : NORMAL_BITS_8;
      end
      if (break_generate_enable) begin
         gen_bits = nine_bit_mode ? GEN_BITS_9 : GEN_BITS_8;
      end else begin
         gen_bits = nine_bit_mode ? NORMAL_BITS_9 : NORMAL_BITS_8;
      end
   end

   // Counting in receiver ticks puts the threshold at 11.0 bits, between 10.35 and 11.05.
   assign detect_rt = {detect_bits, RT_SHIFT_ZERO};

   always_comb begin
      status = 8'h00;
      status[STAT_ACTIVE_BIT] = st.break_active;
      status[STAT_RX_BIT] = st.rx_level;
      status[STAT_SEEN_BIT] = st.break_seen;
      status[STAT_PENDING_BIT] = st.gen_pending;
   end

   assign rate_write = wr_en && (addr == ADDR_RATE_CONTROL || addr == ADDR_FINE_PRESCALER);

   always_comb begin
      next_st = st;

      // Register port: read data is valid only in the cycle after the strobe.
      next_st.rdata = 8'h00;
      if (wr_en && addr == ADDR_RATE_CONTROL) begin
         next_st.rate_control_reg = wdata & RATE_CONTROL_MASK;
      end else if (wr_en && addr == ADDR_FINE_PRESCALER) begin
         next_st.fine_prescaler_reg = wdata;
      end
      if (rd_en) begin
         if (addr == ADDR_RATE_CONTROL) begin
            next_st.rdata = st.rate_control_reg;
         end else if (addr == ADDR_FINE_PRESCALER) begin
            next_st.rdata = st.fine_prescaler_reg;
         end else if (addr == ADDR_BREAK_LENGTH) begin
            next_st.rdata = {3'h0, st.break_len};
            next_st.break_seen = 1'b0;
         end else begin
            next_st.rdata = status;
         end
      end

      // A new setting restarts the whole chain so no divider runs on stale counts.
      next_st.clear = !serial_enable || rate_write;

      // The reference clock is the quad-rate clock; the bus clock is every fourth edge.
      if (st.bus_phase == BUS_PHASE_LAST) begin
         next_st.bus_phase = 2'h0;
      end else begin
         next_st.bus_phase = 2'(st.bus_phase + 1'b1);
      end
      next_st.src_tick = baud_clock_source_sel || (st.bus_phase == BUS_PHASE_LAST);

      // Receiver tick is 16 per bit; with the divide by 4 the chain totals 64.
      next_st.rt_tick = 1'b0;
      next_st.bit_tick = 1'b0;
      if (st.clear) begin
         next_st.rt_pre = 2'h0;
         next_st.rt_count = 4'h0;
      end else begin
         if (power2_tick) begin
            if (st.rt_pre == RT_PRE_LAST) begin
               next_st.rt_pre = 2'h0;
               next_st.rt_tick = 1'b1;
            end else begin
               next_st.rt_pre = 2'(st.rt_pre + 1'b1);
            end
         end
         if (st.rt_tick) begin
            if (st.rt_count == RT_PER_BIT_LAST) begin
               next_st.rt_count = 4'h0;
               next_st.bit_tick = 1'b1;
            end else begin
               next_st.rt_count = 4'(st.rt_count + 1'b1);
            end
         end
      end

      // Only the second and third stages are compared; the first is metastable.
      next_st.rx_sync = {st.rx_sync[1:0], rx_pin};
      if (st.rx_sync[1] == st.rx_sync[2]) begin
         next_st.rx_level = st.rx_sync[2];
      end

      // A break fires once per low stretch, and only after the line was seen high.
      next_st.break_detected = 1'b0;
      if (st.rx_level) begin
         if (st.low_rt != 9'h000) begin
            next_st.break_len = st.low_rt[8:4];
         end
         next_st.low_rt = 9'h000;
         next_st.armed = 1'b1;
      end else if (st.rt_tick && st.low_rt != LOW_RT_MAX) begin
         next_st.low_rt = 9'(st.low_rt + 1'b1);
         if (9'(st.low_rt + 1'b1) == detect_rt && st.armed) begin
            next_st.break_detected = 1'b1;
            next_st.armed = 1'b0;
            next_st.break_seen = 1'b1;
         end
      end

      // Break output starts on a bit boundary so its length is whole bit times.
      if (!serial_enable) begin
         next_st.gen_pending = 1'b0;
         next_st.break_active = 1'b0;
         next_st.gen_count = 5'h00;
      end else begin
         if (send_break && !st.break_active) begin
            next_st.gen_pending = 1'b1;
         end
         if (st.bit_tick) begin
            if (st.gen_pending) begin
               next_st.gen_pending = 1'b0;
               next_st.break_active = 1'b1;
               next_st.gen_count = gen_bits;
            end else if (st.break_active) begin
               if (st.gen_count == 5'h01) begin
                  next_st.break_active = 1'b0;
                  next_st.gen_count = 5'h00;
               end else begin
                  next_st.gen_count = 5'(st.gen_count - 1'b1);
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.rate_control_reg <= RATE_CONTROL_RESET;
         st.fine_prescaler_reg <= FINE_PRESCALER_RESET;
         st.rx_sync <= RX_SYNC_IDLE;
         st.rx_level <= 1'b1;
         st.clear <= 1'b1;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   frac_prescaler u_frac (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .clear(st.clear),
      .in_tick(st.src_tick),
      .prescale_select(prescale_select),
      .clock_insert_select(clock_insert_select),
      .out_tick(frac_tick)
   );

   tick_divider #(.W(4)) u_coarse (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .clear(st.clear),
      .in_tick(frac_tick),
      .divisor(coarse_divisor),
      .out_tick(coarse_tick)
   );

   tick_divider #(.W(8)) u_power2 (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .clear(st.clear),
      .in_tick(coarse_tick),
      .divisor(power2_divisor),
      .out_tick(power2_tick)
   );

   assign rdata = st.rdata;
   assign rt_tick = st.rt_tick;
   assign bit_tick = st.bit_tick;
   assign break_detected = st.break_detected;
   assign break_active = st.break_active;

   default clocking dc @(posedge ref_clk iff clk_en); endclocking
   default disable iff (rst);

   write_readback_a: assert property (wr_en && addr == ADDR_RATE_CONTROL ##1
         rd_en && addr == ADDR_RATE_CONTROL && !wr_en
         |=> rdata == ($past(wdata, 2) & RATE_CONTROL_MASK))
      else $error("rate control readback mismatch");
   reset_rate_a: assert property (@(posedge ref_clk) disable iff (1'b0)
         rst |=> power2_rate_sel == RATE_CONTROL_RESET[POWER2_LSB +: POWER2_W])
      else $error("rate select not cleared by reset");
   coarse_map_a: assert property (coarse_prescale_sel == 2'h3 |-> coarse_divisor == COARSE_DIV_13)
      else $error("coarse divisor mapping wrong");
   bus_source_a: assert property (st.src_tick && !baud_clock_source_sel
         && !$past(baud_clock_source_sel)
         |=> (!st.src_tick || baud_clock_source_sel) [*3])
      else $error("bus clock source faster than one in four");
   bit_chain_a: assert property (bit_tick |-> $past(st.rt_tick) && $past(st.rt_count) == RT_PER_BIT_LAST)
      else $error("bit tick not on the sixteenth receiver tick");
   detect_len_a: assert property (break_detected |-> !st.rx_level && st.low_rt == detect_rt)
      else $error("break flagged at the wrong length");
   lin_filter_a: assert property (break_detected && break_detect_enable |-> st.low_rt >= LIN_MIN_RT)
      else $error("break flagged below eleven bit times");
   gen_len_a: assert property ($rose(break_active) && break_generate_enable && !nine_bit_mode
         |-> st.gen_count == GEN_BITS_8)
      else $error("break length wrong for 8-bit characters");
   lin_both_a: assert property ($rose(break_active) && break_generate_enable
         && break_detect_enable && nine_bit_mode
         |-> st.gen_count == GEN_BITS_9 && detect_rt == {DETECT_BITS_9, RT_SHIFT_ZERO})
      else $error("combined break settings wrong for 9-bit characters");
   break_end_a: assert property (break_active && bit_tick && st.gen_count == 5'h01 |=> !break_active)
      else $error("break did not end after its last bit");

   seen_break_c: cover property (break_detected && break_detect_enable);
   sent_break_c: cover property ($fell(break_active) && break_generate_enable);
   slow_rate_c: cover property (bit_tick && coarse_prescale_sel == 2'h3);
endmodule

// File: tb/lin_node_model.sv
`timescale 1ns/10ps
// A remote node on the receive line: on request it drives one low stretch of whole
// bit times, then idles high for two bit times and reports completion.
module lin_node_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic bit_tick,
   input wire logic start,
   input wire logic [4:0] low_bits,
   output logic rx_pin,
   output logic done
);
   logic [1:0] phase;
   logic [4:0] remaining;

   // Stretches start on a bit boundary so the length in bit times is exact.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rx_pin <= 1'b1;
         done <= 1'b0;
         phase <= 2'h0;
         remaining <= 5'h00;
      end else begin
         done <= 1'b0;
         case (phase)
            2'h0: if (start) phase <= 2'h1;
            2'h1: if (bit_tick) begin
               rx_pin <= 1'b0;
               remaining <= low_bits;
               phase <= 2'h2;
            end
            2'h2: if (bit_tick) begin
               if (remaining == 5'h01) begin
                  rx_pin <= 1'b1;
                  remaining <= 5'h02;
                  phase <= 2'h3;
               end else begin
                  remaining <= remaining - 5'h01;
               end
            end
            default: if (bit_tick) begin
               if (remaining == 5'h01) begin
                  done <= 1'b1;
                  phase <= 2'h0;
               end else begin
                  remaining <= remaining - 5'h01;
               end
            end
         endcase
      end
   end
endmodule

// File: tb/serial_baud_rate_generator_tb.sv
`timescale 1ns/10ps
module serial_baud_rate_generator_tb;
   import baud_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   int rt_n = 0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic serial_enable = 1'b0;
   logic baud_clock_source_sel = 1'b1;
   logic nine_bit_mode = 1'b0;
   logic send_break = 1'b0;
   logic start = 1'b0;
   logic [4:0] low_bits = 5'h00;
   logic [7:0] rdata;
   logic rx_pin, rt_tick, bit_tick, break_detected, break_active, done;
   int bad_count = 0;
   int total_checks = 0;
   logic [7:0] exp_rd[$];
   int exp_per[$];
   int exp_gen[$];
   logic exp_det[$];
   logic rd_d = 1'b0;
   logic seen_det = 1'b0;
   int cyc = 0;
   int last_bt = 0;
   int act_len = 0;
   logic [7:0] rnd = 8'h37;

   always #50 ref_clk = ~ref_clk;

   serial_baud_rate_generator i_serial_baud_rate_generator (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .serial_enable(serial_enable),
      .baud_clock_source_sel(baud_clock_source_sel), .nine_bit_mode(nine_bit_mode),
      .rx_pin(rx_pin), .send_break(send_break), .rt_tick(rt_tick), .bit_tick(bit_tick),
      .break_detected(break_detected), .break_active(break_active));

   lin_node_model i_lin_node_model (
      .ref_clk(ref_clk), .rst(rst), .bit_tick(bit_tick), .start(start),
      .low_bits(low_bits), .rx_pin(rx_pin), .done(done));

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   function automatic int bit_period(input logic [7:0] rc, input logic [7:0] fp, input logic src);
      int c;
      int p;
      case (rc[5:4])
         2'h0: c = 1;
         2'h1: c = 3;
         2'h2: c = 4;
         default: c = 13;
      endcase
      p = (fp[7:5] == 3'h0) ? 64 : 64 * (fp[7:5] + 1) + 2 * fp[4:0];
      return (src ? 1 : 4) * c * (1 << rc[2:0]) * p;
   endfunction

   task automatic fail(input string name, input int e, input int g);
      bad_count++;
      $display("[FAIL] %s expected %0d seen %0d", name, e, g);
   endtask

   task automatic chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) fail(name, e, g);
   endtask

   task automatic chk_count(input string name, input int e, input int g);
      total_checks++;
      if (g != e) fail(name, e, g);
   endtask

   task automatic chk_bit(input string name, input logic e, input logic g);
      total_checks++;
      if (g !== e) fail(name, e, g);
   endtask

   // Results are judged here as they appear, against the oldest note of each kind.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      rd_d <= rd_en;
      if (rd_d && exp_rd.size() > 0) chk_byte("rdata", exp_rd.pop_front(), rdata);
      if (bit_tick === 1'b1) begin
         if (exp_per.size() > 0) chk_count("rt ticks per bit", 16, rt_n);
         if (exp_per.size() > 0) chk_count("bit period", exp_per.pop_front(), cyc - last_bt);
         last_bt <= cyc;
         rt_n <= 0;
      end else if (rt_tick === 1'b1) begin
         rt_n <= rt_n + 1;
      end
      if (break_active === 1'b1) begin
         act_len <= act_len + 1;
      end else if (act_len > 0 && exp_gen.size() > 0) begin
         chk_count("break length", exp_gen.pop_front(), act_len);
         act_len <= 0;
      end
      if (break_detected === 1'b1) seen_det <= 1'b1;
      if (done === 1'b1 && exp_det.size() > 0) begin
         chk_bit("break seen", exp_det.pop_front(), seen_det);
         seen_det <= 1'b0;
      end
   end

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      rd_en <= 1'b0;
      wr_en <= 1'b1;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      exp_rd.push_back(e);
      addr <= a;
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      @(posedge ref_clk);
   endtask

   task automatic quiet();
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic wait_bt();
      do @(posedge ref_clk); while (bit_tick !== 1'b1);
   endtask

   task automatic settle();
      int n;
      n = 0;
      while (exp_per.size() + exp_gen.size() + exp_det.size() > 0 && n < 30000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 30000) fail("pending results", 0, n);
   endtask

   // The port is disabled while the rates change, so a half-written setting is never live.
   task automatic configure(input logic [7:0] rc, input logic [7:0] fp, input logic src);
      serial_enable <= 1'b0;
      baud_clock_source_sel <= src;
      wr(ADDR_RATE_CONTROL, rc);
      wr(ADDR_FINE_PRESCALER, fp);
      quiet();
      serial_enable <= 1'b1;
      @(posedge ref_clk);
   endtask

   // The first bit after a restart may be long, so the second one is measured.
   task automatic period_case(input logic [7:0] rc, input logic [7:0] fp, input logic src);
      configure(rc, fp, src);
      wait_bt();
      @(posedge ref_clk);
      exp_per.push_back(bit_period(rc, fp, src));
      settle();
   endtask

   task automatic line_case(input int n, input logic e);
      exp_det.push_back(e);
      low_bits <= n[4:0];
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      settle();
   endtask

   task automatic break_case(input logic gen, input logic det, input logic nine);
      int thr;
      int len;
      thr = det ? (nine ? 12 : 11) : (nine ? 11 : 10);
      len = gen ? (nine ? 14 : 13) : (nine ? 11 : 10);
      nine_bit_mode <= nine;
      configure({gen, det, 6'h00}, 8'h00, 1'b1);
      line_case(thr - 1, 1'b0);
      line_case(thr + 1, 1'b1);
      wait_bt();
      send_break <= 1'b1;
      exp_gen.push_back(len * 64);
      @(posedge ref_clk);
      send_break <= 1'b0;
      settle();
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge ref_clk);
      fail("watchdog", 0, 1);
      end_of_test();
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rd(ADDR_RATE_CONTROL, RATE_CONTROL_RESET);
      rd(ADDR_FINE_PRESCALER, FINE_PRESCALER_RESET);
      rd(ADDR_BREAK_LENGTH, 8'h00);
      rd(ADDR_STATUS, 8'h02);
      wr(ADDR_STATUS, 8'hff);
      wr(ADDR_RATE_CONTROL, 8'hff);
      rd(ADDR_RATE_CONTROL, 8'hff & RATE_CONTROL_MASK);
      wr(ADDR_FINE_PRESCALER, 8'ha5);
      rd(ADDR_FINE_PRESCALER, 8'ha5);
      // A write while the clock enable is low must be lost.
      clk_en <= 1'b0;
      wr(ADDR_FINE_PRESCALER, 8'h5a);
      clk_en <= 1'b1;
      rd(ADDR_FINE_PRESCALER, 8'ha5);
      rd(ADDR_STATUS, 8'h02);
      quiet();
      $display("test registers done");
      for (int i = 0; i < 4; i++) period_case({2'h0, i[1:0], 4'h0}, 8'h00, 1'b1);
      for (int i = 1; i < 8; i++) period_case({5'h00, i[2:0]}, 8'h00, 1'b1);
      period_case(8'h00, 8'hff, 1'b1);
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         period_case(8'h00, rnd, 1'b1);
      end
      period_case(8'h10, 8'h00, 1'b0);
      $display("test rates done");
      for (int m = 0; m < 8; m++) break_case(m[2], m[1], m[0]);
      $display("test breaks done");
      end_of_test();
   end
endmodule
